/* File: core/fspc_spi_rx.v */
`timescale 1ns/1ps
`default_nettype none

// ============================================================
// serial byte receiver, modes 0 and 3, sampled by clk
module fspc_spi_rx (
  // clock and reset
  input  wire       clk,
  input  wire       resetn,
  // serial pins
  input  wire       spi_sck,
  input  wire       spi_cs_n,
  input  wire       spi_mosi,
  // byte stream
  output reg        rx_byte_vld,
  output reg  [7:0] rx_byte,
  // frame events
  output reg        frame_start,
  output reg        frame_end,
  output reg        frame_ragged
);

  reg [2:0] sck_s;
  reg [2:0] cs_s;
  reg [1:0] mosi_s;
  reg [6:0] shift_r;
  reg [2:0] bitcnt_r;
  wire      sck_rise = sck_s[1] & ~sck_s[2];
  wire      cs_act   = ~cs_s[1];

  // pin synchronisers; edges look only at stages two and three
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sck_s  <= 3'b000;
      cs_s   <= 3'b111;
      mosi_s <= 2'b00;
    end
    else
    begin
      sck_s  <= {sck_s[1:0], spi_sck};
      cs_s   <= {cs_s[1:0], spi_cs_n};
      mosi_s <= {mosi_s[0], spi_mosi};
    end
  end

  // shift on rising serial clock, msb first
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      shift_r      <= 7'h00;
      bitcnt_r     <= 3'd0;
      rx_byte      <= 8'h00;
      rx_byte_vld  <= 1'b0;
      frame_start  <= 1'b0;
      frame_end    <= 1'b0;
      frame_ragged <= 1'b0;
    end
    else
    begin
      rx_byte_vld  <= 1'b0;
      frame_start  <= cs_act & cs_s[2];
      frame_end    <= ~cs_act & ~cs_s[2];
      frame_ragged <= ~cs_act & ~cs_s[2] & (bitcnt_r != 3'd0);
      if (!cs_act)
        bitcnt_r <= 3'd0;
      else if (sck_rise)
      begin
        shift_r  <= {shift_r[5:0], mosi_s[1]};
        bitcnt_r <= bitcnt_r + 3'd1;
        if (bitcnt_r == 3'd7)
        begin
          rx_byte     <= {shift_r, mosi_s[1]};
          rx_byte_vld <= 1'b1;
        end
      end
    end
  end

endmodule // fspc_spi_rx

`default_nettype wire

/* File: core/fspc_top.v */
`include "fspc_regs.vh"
`timescale 1ns/1ps
`default_nettype none

module fspc_top #(
  parameter integer ASSERT_CYC  = `FSPC_ASSERT_DLY_CYC,
  parameter integer RELEASE_CYC = `FSPC_RELEASE_DLY_CYC,
  parameter integer FILT_CNT_W  = 8
) (
  // clock and reset
  input  wire        clk,
  input  wire        resetn,

  // serial link from the host
  input  wire        spi_sck,
  input  wire        spi_cs_n,
  input  wire        spi_mosi,

  // write-protect pin, active low
  input  wire        wp_n_pin,

  // operation check from the array engine
  input  wire        op_req,
  input  wire        op_sel_reg,
  input  wire [3:0]  op_sector,
  input  wire [7:0]  op_page,

  // check answer
  output reg         op_grant,
  output reg         op_deny,
  output reg         busy_start,

  // selection register update from the array engine
  input  wire        sel_erase,
  input  wire        sel_wr,
  input  wire [3:0]  sel_wr_idx,
  input  wire [7:0]  sel_wr_data,

  // selection register read
  input  wire [3:0]  sel_rd_idx,
  output reg  [7:0]  sel_rd_data,

  // status
  output reg         prot_status,
  output reg         wp_active,
  output reg         cmd_prot_on,
  output reg  [16:0] sector_sel_mask
);

  // ============================================================
  // command sequence states
  localparam [5:0] S_IDLE = 6'b000001;
  localparam [5:0] S_B1   = 6'b000010;
  localparam [5:0] S_B2   = 6'b000100;
  localparam [5:0] S_B3   = 6'b001000;
  localparam [5:0] S_B4   = 6'b010000;
  localparam [5:0] S_BAD  = 6'b100000;

  // ============================================================
  // selection decode: sector 0 splits at page 8, the rest are whole bytes
  function sel_hit;
    input [7:0] sel_byte;
    input [3:0] sector;
    input       upper_half;
    begin
      if (sector == 4'd0)
      begin
        if (upper_half)
          sel_hit = &sel_byte[`FSPC_S0B_MSB:`FSPC_S0B_LSB];
        else
          sel_hit = &sel_byte[`FSPC_S0A_MSB:`FSPC_S0A_LSB];
      end
      else
        sel_hit = (sel_byte == `FSPC_SEL_ON);
    end
  endfunction

  // ============================================================
  // signals
  wire       wp_low;
  wire       rx_vld;
  wire [7:0] rx_byte;
  wire       frame_start;
  wire       frame_end;
  wire       frame_ragged;

  reg  [5:0] seq_r;
  reg  [5:0] seq_nxt;
  reg  [7:0] last_r;
  reg  [7:0] last_nxt;
  reg        cmd_en_r;
  reg        cmd_en_nxt;
  reg  [7:0] sel_mem_r [0:`FSPC_SEL_BYTES-1];
  reg  [7:0] tgt_byte;
  reg        tgt_hit;
  reg        deny_nxt;

  wire prot_en  = cmd_en_r | wp_low;
  wire seq_done = (seq_r == S_B4) & ~frame_ragged;
  wire seq_on   = seq_done & (last_r == `FSPC_OP_PROT_ON);
  wire seq_off  = seq_done & (last_r == `FSPC_OP_PROT_OFF);
  wire sel_wr_ok = ~wp_low;

  // ============================================================
  // pin filter and serial receiver
  fspc_wp_filter #(
    .ASSERT_CYC  (ASSERT_CYC),
    .RELEASE_CYC (RELEASE_CYC),
    .CNT_W       (FILT_CNT_W)
  ) u_wp_filter (
    .clk      (clk),
    .resetn   (resetn),
    .wp_n_pin (wp_n_pin),
    .wp_low   (wp_low)
  );

  fspc_spi_rx u_spi_rx (
    .clk          (clk),
    .resetn       (resetn),
    .spi_sck      (spi_sck),
    .spi_cs_n     (spi_cs_n),
    .spi_mosi     (spi_mosi),
    .rx_byte_vld  (rx_vld),
    .rx_byte      (rx_byte),
    .frame_start  (frame_start),
    .frame_end    (frame_end),
    .frame_ragged (frame_ragged)
  );

  // ============================================================
  // command sequence: exactly four whole bytes, judged at deselect
  always @*
  begin
    seq_nxt  = seq_r;
    last_nxt = last_r;
    if (frame_start | frame_end)
      seq_nxt = S_IDLE;
    else if (rx_vld)
    begin
      case (seq_r)
        S_IDLE:
          seq_nxt = (rx_byte == `FSPC_OP_PREFIX0) ? S_B1 : S_BAD;
        S_B1:
          seq_nxt = (rx_byte == `FSPC_OP_PREFIX1) ? S_B2 : S_BAD;
        S_B2:
          seq_nxt = (rx_byte == `FSPC_OP_PREFIX2) ? S_B3 : S_BAD;
        S_B3:
        begin
          last_nxt = rx_byte;
          seq_nxt  = S_B4;
        end
        S_B4:
          seq_nxt = S_BAD; // a fifth byte spoils the frame
        S_BAD:
          seq_nxt = S_BAD;
        default:
          seq_nxt = S_IDLE;
      endcase
    end
  end

  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      seq_r  <= S_IDLE;
      last_r <= 8'h00;
    end
    else
    begin
      seq_r  <= seq_nxt;
      last_r <= last_nxt;
    end
  end

  // ============================================================
  // volatile command protection; cleared only by reset or disable
  always @*
  begin
    cmd_en_nxt = cmd_en_r;
    if (frame_end & seq_on)
      cmd_en_nxt = 1'b1;
    else if (frame_end & seq_off & ~wp_low)
      cmd_en_nxt = 1'b0;
  end

  // power-up state is off, so only the pin can protect until enabled
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      cmd_en_r <= 1'b0;
    else
      cmd_en_r <= cmd_en_nxt;
  end

  // ============================================================
  // selection register storage; pin low freezes it
  genvar gi;
  generate
    for (gi = 0; gi < `FSPC_SEL_BYTES; gi = gi + 1)
    begin : g_sel
      // sector number as a sized constant; a genvar cannot be part-selected
      localparam integer SEC_N = gi;

      always @(posedge clk or negedge resetn)
      begin
        if (!resetn)
          sel_mem_r[gi] <= `FSPC_SEL_RESET;
        else if (sel_erase & sel_wr_ok)
          sel_mem_r[gi] <= `FSPC_SEL_ERASED;
        else if (sel_wr & sel_wr_ok & (sel_wr_idx == SEC_N[3:0]))
          sel_mem_r[gi] <= sel_wr_data;
      end

      // whole-sector view for status, sector 0 shown as two halves
      if (gi == 0)
      begin : g_s0
        always @(posedge clk or negedge resetn)
        begin
          if (!resetn)
            sector_sel_mask[1:0] <= 2'b00;
          else
          begin
            sector_sel_mask[0] <= sel_hit(sel_mem_r[0], 4'd0, 1'b0);
            sector_sel_mask[1] <= sel_hit(sel_mem_r[0], 4'd0, 1'b1);
          end
        end
      end
      else
      begin : g_sn
        always @(posedge clk or negedge resetn)
        begin
          if (!resetn)
            sector_sel_mask[gi+1] <= 1'b0;
          else
            sector_sel_mask[gi+1] <= sel_hit(sel_mem_r[gi], SEC_N[3:0], 1'b0);
        end
      end
    end
  endgenerate

  // ============================================================
  // operation check; the engine starts busy only on a grant
  always @*
  begin
    tgt_byte = sel_mem_r[op_sector];
    tgt_hit  = sel_hit(tgt_byte, op_sector, op_page > `FSPC_S0A_LAST_PAGE);
    if (op_sel_reg)
      deny_nxt = wp_low;
    else
      deny_nxt = prot_en & tgt_hit;
  end

  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      op_grant   <= 1'b0;
      op_deny    <= 1'b0;
      busy_start <= 1'b0;
    end
    else
    begin
      op_grant   <= op_req & ~deny_nxt;
      op_deny    <= op_req & deny_nxt;
      busy_start <= op_req & ~deny_nxt;
    end
  end

  // ============================================================
  // status and read port, all from flops
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      prot_status <= 1'b0;
      wp_active   <= 1'b0; // filter resets high, as the pull-up leaves it
      cmd_prot_on <= 1'b0;
      sel_rd_data <= 8'h00;
    end
    else
    begin
      prot_status <= prot_en;
      wp_active   <= wp_low;
      cmd_prot_on <= cmd_en_r;
      sel_rd_data <= sel_mem_r[sel_rd_idx];
    end
  end

endmodule // fspc_top

`default_nettype wire

/* File: core/fspc_wp_filter.v */
`timescale 1ns/1ps
`default_nettype none

// ============================================================
// write-protect pin synchroniser and noise filter
module fspc_wp_filter #(
  parameter integer ASSERT_CYC  = 20,
  parameter integer RELEASE_CYC = 20,
  parameter integer CNT_W       = 8
) (
  // clock and reset
  input  wire clk,
  input  wire resetn,
  // pin side
  input  wire wp_n_pin,
  // filtered level
  output reg  wp_low
);

  reg [1:0]       sync_r;
  reg [CNT_W-1:0] cnt_r;
  wire            pin_low = ~sync_r[1];
  wire [CNT_W-1:0] need = wp_low ? RELEASE_CYC[CNT_W-1:0] : ASSERT_CYC[CNT_W-1:0];

  // two flops before any logic; resets high, like the pulled-up pad
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      sync_r <= 2'b11;
    else
      sync_r <= {sync_r[0], wp_n_pin};
  end

  // a new level must hold for the whole count, so short glitches are dropped
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cnt_r  <= {CNT_W{1'b0}};
      wp_low <= 1'b0;
    end
    else if (pin_low == wp_low)
      cnt_r <= {CNT_W{1'b0}};
    else if (cnt_r + 1'b1 >= need)
    begin
      cnt_r  <= {CNT_W{1'b0}};
      wp_low <= pin_low;
    end
    else
      cnt_r <= cnt_r + 1'b1;
  end

endmodule // fspc_wp_filter

`default_nettype wire

/* File: inc/fspc_regs.vh */
`ifndef FSPC_REGS_VH
`define FSPC_REGS_VH

// ============================================================
// command bytes of the protection sequences
`define FSPC_OP_PREFIX0      8'h3D
`define FSPC_OP_PREFIX1      8'h2A
`define FSPC_OP_PREFIX2      8'h7F
`define FSPC_OP_PROT_ON      8'hA9
`define FSPC_OP_PROT_OFF     8'h9A

// ============================================================
// selection register layout
`define FSPC_SEL_BYTES       16
`define FSPC_SEL_IDX_W       4
`define FSPC_SEL_ON          8'hFF
`define FSPC_SEL_OFF         8'h00
`define FSPC_SEL_ERASED      8'hFF
`define FSPC_SEL_RESET       8'h00
`define FSPC_S0A_MSB         7
`define FSPC_S0A_LSB         6
`define FSPC_S0B_MSB         5
`define FSPC_S0B_LSB         4
`define FSPC_S0A_LAST_PAGE   8'h07

// ============================================================
// timing: clock rate and the write-protect filter delays
`define FSPC_CLK_MHZ         200
`define FSPC_ASSERT_DLY_NS   100
`define FSPC_RELEASE_DLY_NS  100
`define FSPC_ASSERT_DLY_CYC  ((`FSPC_ASSERT_DLY_NS * `FSPC_CLK_MHZ) / 1000)
`define FSPC_RELEASE_DLY_CYC ((`FSPC_RELEASE_DLY_NS * `FSPC_CLK_MHZ) / 1000)

`endif

/* File: testbench/fspc_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========
// host controller: serial frames and write-protect pin
module fspc_host_model (
  // serial link
  output var logic spi_sck,
  output var logic spi_cs_n,
  output var logic spi_mosi,
  // write-protect pin
  output var logic wp_n_pin
);
  // idle: deselected, clock still, pin released
  initial
  begin
    spi_sck = 1'b0;
    spi_cs_n = 1'b1;
    spi_mosi = 1'b0;
    wp_n_pin = 1'b1; // released pin sits at the pull-up
  end

  task automatic set_wp(input logic v);
    wp_n_pin = v;
  endtask

  // n bits msb first, mode 0, 125 ns bit time; odd start offset keeps phase apart
  task automatic send(input logic [31:0] d, input int n);
    int k;
    #1.3;
    spi_cs_n = 1'b0;
    for (k = 31; k > 31 - n; k--)
    begin
      spi_mosi = d[k];
      #62.5;
      spi_sck = 1'b1;
      #62.5;
      spi_sck = 1'b0;
    end
    #62.5;
    spi_cs_n = 1'b1; // deselect closes the command
    spi_mosi = ~spi_mosi; // released line must not hold the last bit
  endtask
endmodule // fspc_host_model
`default_nettype wire

/* File: testbench/fspc_prot_chk_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========
// port-level checks of the protection control
module fspc_prot_chk #(
  parameter integer ASSERT_CYC  = 20,
  parameter integer RELEASE_CYC = 20
) (
  // clock and reset
  input wire logic        clk,
  input wire logic        resetn,
  // pins
  input wire logic        spi_cs_n,
  input wire logic        wp_n_pin,
  // operation check
  input wire logic        op_req,
  input wire logic        op_sel_reg,
  input wire logic        op_grant,
  input wire logic        op_deny,
  input wire logic        busy_start,
  // selection register
  input wire logic        sel_erase,
  input wire logic        sel_wr,
  input wire logic [3:0]  sel_wr_idx,
  input wire logic [7:0]  sel_wr_data,
  // status
  input wire logic        prot_status,
  input wire logic        wp_active,
  input wire logic        cmd_prot_on,
  input wire logic [16:0] sector_sel_mask
);
  localparam int LOW_ACC = ASSERT_CYC + 3;
  logic [7:0] low_cnt_r;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  // ==========
  // run length of a low pin; saturates so a tied-low pin never wraps
  always @(posedge clk or negedge resetn)
    if (!resetn)
      low_cnt_r <= 8'h00;
    else if (wp_n_pin)
      low_cnt_r <= 8'h00;
    else if (low_cnt_r != 8'hFF)
      low_cnt_r <= low_cnt_r + 8'h01;

  // ==========
  // writes with the pin high at the write and the edge after
  sequence wr_sector_s;
    sel_wr && !sel_erase && !wp_active && sel_wr_idx != 4'h0 ##1 !wp_active && !sel_erase;
  endsequence
  sequence erase_s;
    sel_erase && !wp_active ##1 !wp_active;
  endsequence

  one_answer_a: assert property (op_req |=> op_grant ^ op_deny)
    else $error("check not answered once");
  no_answer_a: assert property (!op_req |=> !op_grant && !op_deny)
    else $error("answer without request");
  busy_pair_a: assert property (busy_start == op_grant)
    else $error("busy differs from grant");
  status_on_a: assert property ((cmd_prot_on || wp_active) [*2] |-> prot_status)
    else $error("status misses protection");
  status_off_a: assert property ((!cmd_prot_on && !wp_active) [*2] |-> !prot_status)
    else $error("status on without source");
  pin_assert_a: assert property (low_cnt_r == LOW_ACC |-> ##[0:3] (wp_active && prot_status))
    else $error("low pin not protecting");
  reg_lock_a: assert property (op_req && op_sel_reg && wp_active |=> op_deny || !wp_active)
    else $error("register change granted");
  wp_hold_a: assert property ((sel_wr || sel_erase) && wp_active ##1 wp_active |=> $stable(sector_sel_mask))
    else $error("mask changed under pin");
  erase_all_a: assert property (erase_s |=> sector_sel_mask == 17'h1_FFFF)
    else $error("erase left a gap");
  sector_map_a: assert property (wr_sector_s |=>
    sector_sel_mask[$past(sel_wr_idx, 2) + 1] == ($past(sel_wr_data, 2) == 8'hFF))
    else $error("sector mask wrong");
  cmd_edge_a: assert property ($changed(cmd_prot_on) |-> $past(spi_cs_n, 3))
    else $error("command state moved in frame");
  off_ignored_a: assert property ($fell(cmd_prot_on) |-> !$past(wp_active))
    else $error("disable taken under pin");
endmodule // fspc_prot_chk

bind fspc_top fspc_prot_chk #(.ASSERT_CYC(ASSERT_CYC), .RELEASE_CYC(RELEASE_CYC)) u_fspc_prot_chk (
  .clk, .resetn, .spi_cs_n, .wp_n_pin, .op_req, .op_sel_reg, .op_grant, .op_deny, .busy_start,
  .sel_erase, .sel_wr, .sel_wr_idx, .sel_wr_data, .prot_status, .wp_active, .cmd_prot_on, .sector_sel_mask
);
`default_nettype wire

/* File: testbench/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========
// bench: host frames, pin moves, selection writes, operation checks
module tb_top;
  logic        clk = 1'b0;
  logic        resetn = 1'b0;
  logic        spi_sck, spi_cs_n, spi_mosi, wp_n_pin;
  logic        op_req = 1'b0, op_sel_reg = 1'b0, sel_erase = 1'b0, sel_wr = 1'b0;
  logic [3:0]  op_sector = 4'h0, sel_wr_idx = 4'h0, sel_rd_idx = 4'h0;
  logic [7:0]  op_page = 8'h00, sel_wr_data = 8'h00, sel_rd_data;
  logic        op_grant, op_deny, busy_start, prot_status, wp_active, cmd_prot_on;
  logic [16:0] sector_sel_mask, exp_mask;
  logic [2:0]  exp_q[$];
  int          fail_count = 0, tests_run = 0, cyc = 0, i;
  integer      seed = 32'h532c;

  always #2.5 clk = ~clk;

  fspc_top #(.ASSERT_CYC(4), .RELEASE_CYC(4)) u_fspc_top (
    .clk, .resetn, .spi_sck, .spi_cs_n, .spi_mosi, .wp_n_pin, .op_req, .op_sel_reg, .op_sector, .op_page,
    .op_grant, .op_deny, .busy_start, .sel_erase, .sel_wr, .sel_wr_idx, .sel_wr_data, .sel_rd_idx,
    .sel_rd_data, .prot_status, .wp_active, .cmd_prot_on, .sector_sel_mask
  );
  fspc_host_model u_fspc_host_model (.spi_sck, .spi_cs_n, .spi_mosi, .wp_n_pin);

  task automatic chk(input logic [16:0] got, input logic [16:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_of_test;
    $display("comparisons %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // one-cycle request per call, so no stray answers during frames; note {busy, grant, deny}
  task automatic op(input logic sr, input logic [3:0] s, input logic [7:0] p, input logic deny);
    @(negedge clk);
    op_req = 1'b1;
    op_sel_reg = sr;
    op_sector = s;
    op_page = p;
    exp_q.push_back({!deny, !deny, deny});
    @(negedge clk);
    op_req = 1'b0;
  endtask

  task automatic wr(input logic e, input logic [3:0] a, input logic [7:0] d);
    @(negedge clk);
    op_req = 1'b0;
    sel_erase = e;
    sel_wr = !e;
    sel_wr_idx = a;
    sel_wr_data = d;
    @(negedge clk);
    sel_erase = 1'b0;
    sel_wr = 1'b0;
    repeat (3) @(negedge clk);
  endtask

  task automatic pin(input logic v, input int n);
    @(negedge clk);
    op_req = 1'b0;
    u_fspc_host_model.set_wp(v);
    repeat (n) @(negedge clk);
  endtask

  task automatic frame(input logic [31:0] d, input int n);
    u_fspc_host_model.send(d, n);
    repeat (8) @(negedge clk);
  endtask

  // each answer pulse is matched with the oldest note
  always @(posedge clk)
  begin
    #1;
    if (op_grant !== 1'b0 || op_deny !== 1'b0)
      chk({busy_start, op_grant, op_deny}, exp_q.size() ? exp_q.pop_front() : 3'b000);
  end

  // hang guard
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fail_count++;
      end_of_test();
    end
  end

  initial
  begin
    repeat (20) @(negedge clk);
    resetn = 1'b1;
    @(negedge clk);
    chk({prot_status, cmd_prot_on, wp_active}, 3'b000);
    exp_mask = 17'h0_0001;
    wr(1'b0, 4'h0, 8'hC5);
    for (i = 1; i < 16; i++)
    begin
      sel_rd_idx = i[3:0];
      wr(1'b0, i[3:0], ($random(seed) & 1) ? 8'hFF : 8'h00);
      exp_mask[i + 1] = (sel_wr_data == 8'hFF);
      chk(sel_rd_data, sel_wr_data);
    end
    chk(sector_sel_mask, exp_mask);
    op(1'b0, 4'h5, 8'h00, 1'b0);
    frame(32'h3D2A_7FA9, 32);
    chk({prot_status, cmd_prot_on}, 2'b11);
    for (i = 0; i < 16; i++)
      op(1'b0, i[3:0], 8'hC8, exp_mask[i + 1]);
    op(1'b0, 4'h0, 8'h07, 1'b1);
    op(1'b1, 4'h0, 8'h00, 1'b0);
    frame(32'h3D2A_7F9A, 24);
    frame(32'h3D2A_7F9B, 32);
    chk(cmd_prot_on, 1'b1);
    frame(32'h3D2A_7F9A, 32);
    chk(prot_status, 1'b0);
    pin(1'b0, 2);
    pin(1'b1, 12);
    chk(wp_active, 1'b0);
    pin(1'b0, 10);
    chk({wp_active, prot_status}, 2'b11);
    pin(1'b1, 2);
    pin(1'b0, 12);
    chk(wp_active, 1'b1);
    wr(1'b1, 4'h0, 8'h00);
    wr(1'b0, 4'h2, ~exp_mask[3] ? 8'hFF : 8'h00);
    chk(sector_sel_mask, exp_mask);
    op(1'b1, 4'h0, 8'h00, 1'b1);
    frame(32'h3D2A_7FA9, 32);
    frame(32'h3D2A_7F9A, 32);
    chk(cmd_prot_on, 1'b1);
    pin(1'b1, 12);
    chk(prot_status, 1'b1);
    frame(32'h3D2A_7F9A, 32);
    chk(prot_status, 1'b0);
    pin(1'b0, 10);
    pin(1'b1, 12);
    chk(prot_status, 1'b0);
    wr(1'b1, 4'h0, 8'h00);
    chk(sector_sel_mask, 17'h1_FFFF);
    frame(32'h3D2A_7FA9, 32);
    op(1'b0, 4'h9, 8'h00, 1'b1);
    pin(1'b1, 4);
    chk(exp_q.size(), 17'h0_0000);
    end_of_test();
  end
endmodule // tb_top
`default_nettype wire
